// ### core/panel_mux_pkg.sv
// Shared constants for the panel pin multiplexer
package panel_mux_pkg;

    // Panel interface mode select encoding, one code per mode
    typedef enum logic [1:0] {
        MODE_RGB_SER = 2'b00,  // Mode 1: primary RGB, secondary serial
        MODE_PAR_SER = 2'b01,  // Mode 2: primary parallel, secondary serial
        MODE_PAR_PAR = 2'b10,  // Mode 3: both parallel
        MODE_RGB_PAR = 2'b11   // Mode 4: primary RGB, secondary parallel
    } panel_mode_t;

    // Reset values of the registered selects
    localparam panel_mode_t MODE_RESET       = MODE_RGB_SER;
    localparam logic        POWER_SAVE_RESET = 1'b0;
    localparam logic        SER_BYPASS_RESET = 1'b0;
    localparam logic        PAR_BYPASS_RESET = 1'b0;

    // Level driven on an unused or held-off output
    localparam logic        OUT_IDLE         = 1'b0;
    // Inactive level of an active-low select
    localparam logic        SEL_IDLE_N       = 1'b1;

    // Synchroniser depth used on every crossing
    localparam int          SYNC_STAGES      = 2;

endpackage

// ### core/level_sync.sv
// Two-flop level synchroniser into the destination clock domain
module level_sync #(
    parameter int          STAGES    = panel_mux_pkg::SYNC_STAGES,
    parameter logic        RESET_VAL = 1'b0
) (
    // Destination clock and reset
    input  wire logic      clk_i,
    input  wire logic      rst_n_i,
    input  wire logic      ce_i,
    // Asynchronous level and its synchronised copy
    input  wire logic      level_i,
    output logic           level_o
);

    logic [STAGES-1:0]     chain_reg;
    logic [STAGES-1:0]     chain_next;

    // Shift the level along the chain; only the last flop is read
    always_comb begin
        chain_next = {chain_reg[STAGES-2:0], level_i};
    end

    // Register the chain
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            chain_reg <= {STAGES{RESET_VAL}};
        end else if (ce_i) begin
            chain_reg <= chain_next;
        end
    end

    assign level_o = chain_reg[STAGES-1];

endmodule

// ### core/lcd_panel_pin_mux.sv
// Panel pin multiplexer: routes controller and host signals to panel pins
// Notes on behaviour
// - Four panel modes select pin roles
// - Data valid driven only in modes 1, 4
// - Select one: serial modes 1,4; parallel 2,3
// - Parallel bypass forwards host select one
// - Select two: serial modes 1,2; parallel 3,4
// - Modes 1,2 save/serial bypass: host select pin
// - Parallel bypass, or serial bypass in modes 3,4, forwards host select two
// - Serial clock: primary/secondary/unused/primary per mode
// - Save in modes 1,2 or serial bypass: clock follows host pin
// - Serial bypass drives host serial clock
// - Command flag routed per mode like clock
// - Save in modes 1,2 or serial bypass: flag follows host pin
// - Serial bypass drives host command flag
// - Serial data routed per mode like clock
// - Save in modes 1,2 or serial bypass: data follows host pin
// - Serial bypass drives host serial data
// - Primary vsync is parallel panel, modes 2-4
// - Secondary vsync serial modes 1,2; parallel 3,4
module lcd_panel_pin_mux (
    // System clock domain
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    // Link clock domain for the vsync pins
    input  wire logic        link_clk_i,
    input  wire logic        link_rst_n_i,
    // Configuration selects, sampled on clk_i
    input  wire logic [1:0]  mode_i,
    input  wire logic        power_save_i,
    input  wire logic        serial_bypass_i,
    input  wire logic        parallel_bypass_i,
    // Display controller panel-side signals
    input  wire logic        ctl_data_valid_i,
    input  wire logic        ctl_pri_ser_sel_n_i,
    input  wire logic        ctl_pri_par_sel_n_i,
    input  wire logic        ctl_sec_ser_sel_n_i,
    input  wire logic        ctl_sec_par_sel_n_i,
    input  wire logic        ctl_pri_sclk_i,
    input  wire logic        ctl_sec_sclk_i,
    input  wire logic        ctl_pri_cmd_i,
    input  wire logic        ctl_sec_cmd_i,
    input  wire logic        ctl_pri_sdata_i,
    input  wire logic        ctl_sec_sdata_i,
    // Host pins passed straight through in bypass
    input  wire logic        host_serial_select_pin_i,
    input  wire logic        host_serial_clock_pin_i,
    input  wire logic        host_serial_cmd_flag_pin_i,
    input  wire logic        host_serial_data_pin_i,
    input  wire logic        host_select_one_i,
    input  wire logic        host_select_two_i,
    // Panel output pins
    output logic             panel_data_valid_out_o,
    output logic             panel_select_one_n_o,
    output logic             panel_select_two_n_o,
    output logic             panel_serial_clock_out_o,
    output logic             panel_cmd_flag_out_o,
    output logic             panel_serial_data_out_o,
    // Vertical sync pins from the panels
    input  wire logic        primary_vsync_in_i,
    input  wire logic        secondary_vsync_in_i,
    // Vsync roles in the system domain
    output logic             pri_par_vsync_o,
    output logic             sec_ser_vsync_o,
    output logic             sec_par_vsync_o
);

    // ****************************************************************
    // Registered selects
    // ****************************************************************

    panel_mux_pkg::panel_mode_t mode_reg;
    panel_mux_pkg::panel_mode_t mode_next;
    logic                    psave_reg;
    logic                    psave_next;
    logic                    sbyp_reg;
    logic                    sbyp_next;
    logic                    pbyp_reg;
    logic                    pbyp_next;

    // Next values of the selects; clock enable holds them
    always_comb begin
        mode_next  = mode_reg;
        psave_next = psave_reg;
        sbyp_next  = sbyp_reg;
        pbyp_next  = pbyp_reg;
        if (ce_i) begin
            mode_next  = panel_mux_pkg::panel_mode_t'(mode_i);
            psave_next = power_save_i;
            sbyp_next  = serial_bypass_i;
            pbyp_next  = parallel_bypass_i;
        end
    end

    // Register the selects; reset picks the default mode
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            mode_reg  <= panel_mux_pkg::MODE_RESET;
            psave_reg <= panel_mux_pkg::POWER_SAVE_RESET;
            sbyp_reg  <= panel_mux_pkg::SER_BYPASS_RESET;
            pbyp_reg  <= panel_mux_pkg::PAR_BYPASS_RESET;
        end else begin
            mode_reg  <= mode_next;
            psave_reg <= psave_next;
            sbyp_reg  <= sbyp_next;
            pbyp_reg  <= pbyp_next;
        end
    end

    // ****************************************************************
    // Output routing
    // ****************************************************************

    logic                    sec_serial;
    logic                    host_serial;

    // Secondary panel is serial in modes 1 and 2
    assign sec_serial  = (mode_reg == panel_mux_pkg::MODE_RGB_SER) ||
                         (mode_reg == panel_mux_pkg::MODE_PAR_SER);
    // Host owns the serial pins under serial bypass, or save in modes 1 and 2
    assign host_serial = sbyp_reg || (psave_reg && sec_serial);

    // Pure gate-level routing so pass-through adds no cycle
    always_comb begin
        panel_data_valid_out_o   = panel_mux_pkg::OUT_IDLE;
        panel_select_one_n_o     = ctl_pri_ser_sel_n_i;
        panel_select_two_n_o     = ctl_sec_ser_sel_n_i;
        panel_serial_clock_out_o = panel_mux_pkg::OUT_IDLE;
        panel_cmd_flag_out_o     = panel_mux_pkg::OUT_IDLE;
        panel_serial_data_out_o  = panel_mux_pkg::OUT_IDLE;
        case (mode_reg)
            panel_mux_pkg::MODE_RGB_SER: begin
                panel_data_valid_out_o   = ctl_data_valid_i;
                panel_select_one_n_o     = ctl_pri_ser_sel_n_i;
                panel_select_two_n_o     = ctl_sec_ser_sel_n_i;
                panel_serial_clock_out_o = ctl_pri_sclk_i;
                panel_cmd_flag_out_o     = ctl_pri_cmd_i;
                panel_serial_data_out_o  = ctl_pri_sdata_i;
            end
            panel_mux_pkg::MODE_PAR_SER: begin
                panel_select_one_n_o     = ctl_pri_par_sel_n_i;
                panel_select_two_n_o     = ctl_sec_ser_sel_n_i;
                panel_serial_clock_out_o = ctl_sec_sclk_i;
                panel_cmd_flag_out_o     = ctl_sec_cmd_i;
                panel_serial_data_out_o  = ctl_sec_sdata_i;
            end
            panel_mux_pkg::MODE_PAR_PAR: begin
                panel_select_one_n_o     = ctl_pri_par_sel_n_i;
                panel_select_two_n_o     = ctl_sec_par_sel_n_i;
            end
            panel_mux_pkg::MODE_RGB_PAR: begin
                panel_data_valid_out_o   = ctl_data_valid_i;
                panel_select_one_n_o     = ctl_pri_ser_sel_n_i;
                panel_select_two_n_o     = ctl_sec_par_sel_n_i;
                panel_serial_clock_out_o = ctl_pri_sclk_i;
                panel_cmd_flag_out_o     = ctl_pri_cmd_i;
                panel_serial_data_out_o  = ctl_pri_sdata_i;
            end
            default: begin
                panel_data_valid_out_o   = panel_mux_pkg::OUT_IDLE;
            end
        endcase
        // Host serial pins take over the serial lines
        if (host_serial) begin
            panel_serial_clock_out_o = host_serial_clock_pin_i;
            panel_cmd_flag_out_o     = host_serial_cmd_flag_pin_i;
            panel_serial_data_out_o  = host_serial_data_pin_i;
        end
        // Selects: parallel bypass first, then host serial select, then host select two under serial bypass
        if (pbyp_reg) begin
            panel_select_one_n_o = host_select_one_i;
            panel_select_two_n_o = host_select_two_i;
        end else if (host_serial && sec_serial) begin
            panel_select_two_n_o = host_serial_select_pin_i;
        end else if (sbyp_reg) begin
            panel_select_two_n_o = host_select_two_i;
        end
        // Reset holds pins quiet, selects inactive
        if (!rst_n_i) begin
            panel_data_valid_out_o   = panel_mux_pkg::OUT_IDLE;
            panel_serial_clock_out_o = panel_mux_pkg::OUT_IDLE;
            panel_cmd_flag_out_o     = panel_mux_pkg::OUT_IDLE;
            panel_serial_data_out_o  = panel_mux_pkg::OUT_IDLE;
            panel_select_one_n_o     = panel_mux_pkg::SEL_IDLE_N;
            panel_select_two_n_o     = panel_mux_pkg::SEL_IDLE_N;
        end
    end

    // ****************************************************************
    // Vertical sync capture and crossing
    // ****************************************************************

    logic                    pri_vs_link;
    logic                    sec_vs_link;
    logic                    pri_vs_sys;
    logic                    sec_vs_sys;
    logic                    pri_par_vs_reg;
    logic                    pri_par_vs_next;
    logic                    sec_ser_vs_reg;
    logic                    sec_ser_vs_next;
    logic                    sec_par_vs_reg;
    logic                    sec_par_vs_next;

    // Pins are sampled on the link clock first
    level_sync #(.STAGES(panel_mux_pkg::SYNC_STAGES), .RESET_VAL(1'b0)) u_pri_link (
        .clk_i   (link_clk_i),
        .rst_n_i (link_rst_n_i),
        .ce_i    (1'b1),
        .level_i (primary_vsync_in_i),
        .level_o (pri_vs_link)
    );

    level_sync #(.STAGES(panel_mux_pkg::SYNC_STAGES), .RESET_VAL(1'b0)) u_sec_link (
        .clk_i   (link_clk_i),
        .rst_n_i (link_rst_n_i),
        .ce_i    (1'b1),
        .level_i (secondary_vsync_in_i),
        .level_o (sec_vs_link)
    );

    // Then the levels cross into the system clock
    level_sync #(.STAGES(panel_mux_pkg::SYNC_STAGES), .RESET_VAL(1'b0)) u_pri_sys (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .ce_i    (ce_i),
        .level_i (pri_vs_link),
        .level_o (pri_vs_sys)
    );

    level_sync #(.STAGES(panel_mux_pkg::SYNC_STAGES), .RESET_VAL(1'b0)) u_sec_sys (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .ce_i    (ce_i),
        .level_i (sec_vs_link),
        .level_o (sec_vs_sys)
    );

    // Give each vsync its role for the current mode
    always_comb begin
        pri_par_vs_next = pri_par_vs_reg;
        sec_ser_vs_next = sec_ser_vs_reg;
        sec_par_vs_next = sec_par_vs_reg;
        if (ce_i) begin
            pri_par_vs_next = pri_vs_sys &&
                              (mode_reg != panel_mux_pkg::MODE_RGB_SER);
            sec_ser_vs_next = sec_vs_sys && sec_serial;
            sec_par_vs_next = sec_vs_sys && !sec_serial;
        end
    end

    // Register the vsync roles
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pri_par_vs_reg <= 1'b0;
            sec_ser_vs_reg <= 1'b0;
            sec_par_vs_reg <= 1'b0;
        end else begin
            pri_par_vs_reg <= pri_par_vs_next;
            sec_ser_vs_reg <= sec_ser_vs_next;
            sec_par_vs_reg <= sec_par_vs_next;
        end
    end

    assign pri_par_vsync_o = pri_par_vs_reg;
    assign sec_ser_vsync_o = sec_ser_vs_reg;
    assign sec_par_vsync_o = sec_par_vs_reg;

    // ****************************************************************
    // Checks
    // ****************************************************************

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_mode_sampled;
        ce_i ##1 1'b1;
    endsequence

    chk_mode_capture: assert property (
        ce_i |=> (mode_reg == $past(mode_i)))
        else $error("mode select not captured");
    chk_valid_route: assert property (
        (mode_reg == panel_mux_pkg::MODE_PAR_SER ||
         mode_reg == panel_mux_pkg::MODE_PAR_PAR) |-> !panel_data_valid_out_o)
        else $error("data valid driven in parallel mode");
    chk_sel_one: assert property (
        (!pbyp_reg && mode_reg == panel_mux_pkg::MODE_PAR_PAR)
        |-> panel_select_one_n_o == ctl_pri_par_sel_n_i)
        else $error("select one wrong in mode 3");
    chk_pbyp_one: assert property (
        pbyp_reg |-> panel_select_one_n_o == host_select_one_i)
        else $error("parallel bypass select one wrong");
    chk_sel_two_par: assert property (
        (!pbyp_reg && !sbyp_reg && !sec_serial)
        |-> panel_select_two_n_o == ctl_sec_par_sel_n_i)
        else $error("select two wrong in parallel mode");
    chk_save_sel: assert property (
        (s_mode_sampled ##0 (!pbyp_reg && psave_reg && sec_serial))
        |-> panel_select_two_n_o == host_serial_select_pin_i)
        else $error("power save select two wrong");
    chk_sbyp_two: assert property (
        (sbyp_reg && !pbyp_reg && !sec_serial)
        |-> panel_select_two_n_o == host_select_two_i)
        else $error("serial bypass select two wrong");
    chk_clk_unused: assert property (
        (!sbyp_reg && mode_reg == panel_mux_pkg::MODE_PAR_PAR)
        |-> !panel_serial_clock_out_o && !panel_cmd_flag_out_o)
        else $error("serial lines active in mode 3");
    chk_host_serial: assert property (
        ($rose(sbyp_reg) ##0 sbyp_reg [*2])
        |-> panel_serial_data_out_o == host_serial_data_pin_i &&
            panel_serial_clock_out_o == host_serial_clock_pin_i)
        else $error("serial bypass lines not passed");
    chk_vsync_role: assert property (
        (ce_i && sec_vs_sys && mode_reg == panel_mux_pkg::MODE_RGB_SER)
        ##1 (mode_reg == panel_mux_pkg::MODE_RGB_SER) |-> sec_ser_vsync_o && !sec_par_vsync_o)
        else $error("secondary vsync role wrong");

endmodule

// ### tb/panel_model.sv
// Behavioural panel pair that drives the vertical sync pins from its own link clock
module panel_model (
    // Link clock of the panels
    input  wire logic link_clk_i,
    // Requested sync levels from the bench
    input  wire logic pri_level_i,
    input  wire logic sec_level_i,
    // Sync pins towards the multiplexer
    output logic      primary_vsync_in_o,
    output logic      secondary_vsync_in_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // Unused sync pins sit at ground, so both start low
    initial begin
        primary_vsync_in_o   = 1'b0;
        secondary_vsync_in_o = 1'b0;
    end

    // Sync levels change only on the panels' own clock, unrelated to the system clock
    always @(posedge link_clk_i) begin
        primary_vsync_in_o   <= pri_level_i;
        secondary_vsync_in_o <= sec_level_i;
    end
endmodule

// ### tb/lcd_panel_pin_mux_test.sv
// Self-checking bench for the panel pin multiplexer
module lcd_panel_pin_mux_test;
    timeunit 1ns;
    timeprecision 100ps;

    // ****************************************
    // Clocks, stimulus and observed pins
    // ****************************************
    logic        clk        = 1'b0;
    logic        link_clk   = 1'b0;
    logic        rst_n, link_rst_n, ce, ps, sb, pb, pri_req, sec_req;
    wire         pv, sv;
    logic [1:0]  mode;
    logic [16:0] pat;
    wire  [5:0]  pins;
    wire  [2:0]  roles;
    logic [5:0]  exp_p;
    int          errors     = 0;
    int          n_checks   = 0;
    // Every input bit has its own nonzero code across the patterns, so no two sources look alike
    localparam logic [16:0] test_pats [5] = '{17'h06666, 17'h18000, 17'h15555,
                                              17'h07F80, 17'h07878};

    // System clock 100 MHz, link clock 6 ns with an odd phase offset
    initial begin
        forever #5 clk = ~clk;
    end
    initial begin
        #1.3;
        forever #3 link_clk = ~link_clk;
    end

    // Device and panel pair
    lcd_panel_pin_mux i_dut (
        .clk_i                      (clk),
        .rst_n_i                    (rst_n),
        .ce_i                       (ce),
        .link_clk_i                 (link_clk),
        .link_rst_n_i               (link_rst_n),
        .mode_i                     (mode),
        .power_save_i               (ps),
        .serial_bypass_i            (sb),
        .parallel_bypass_i          (pb),
        .ctl_data_valid_i           (pat[0]),
        .ctl_pri_ser_sel_n_i        (pat[1]),
        .ctl_pri_par_sel_n_i        (pat[2]),
        .ctl_sec_ser_sel_n_i        (pat[3]),
        .ctl_sec_par_sel_n_i        (pat[4]),
        .ctl_pri_sclk_i             (pat[5]),
        .ctl_sec_sclk_i             (pat[6]),
        .ctl_pri_cmd_i              (pat[7]),
        .ctl_sec_cmd_i              (pat[8]),
        .ctl_pri_sdata_i            (pat[9]),
        .ctl_sec_sdata_i            (pat[10]),
        .host_serial_select_pin_i   (pat[11]),
        .host_serial_clock_pin_i    (pat[12]),
        .host_serial_cmd_flag_pin_i (pat[13]),
        .host_serial_data_pin_i     (pat[14]),
        .host_select_one_i          (pat[15]),
        .host_select_two_i          (pat[16]),
        .panel_data_valid_out_o     (pins[5]),
        .panel_select_one_n_o       (pins[4]),
        .panel_select_two_n_o       (pins[3]),
        .panel_serial_clock_out_o   (pins[2]),
        .panel_cmd_flag_out_o       (pins[1]),
        .panel_serial_data_out_o    (pins[0]),
        .primary_vsync_in_i         (pv),
        .secondary_vsync_in_i       (sv),
        .pri_par_vsync_o            (roles[2]),
        .sec_ser_vsync_o            (roles[1]),
        .sec_par_vsync_o            (roles[0])
    );
    panel_model i_panels (
        .link_clk_i           (link_clk),
        .pri_level_i          (pri_req),
        .sec_level_i          (sec_req),
        .primary_vsync_in_o   (pv),
        .secondary_vsync_in_o (sv)
    );

    // ****************************************
    // Expected values and checking tasks
    // ****************************************
    // Pin levels {valid, sel1, sel2, sclk, cmd, sdata} for given selects and input pattern
    function automatic logic [5:0] exp_pins(input logic [1:0] m, input logic p_s, input logic s_b,
                                            input logic p_b, input logic [16:0] p);
        logic       rgb;
        logic       ser2;
        logic       s1;
        logic       s2;
        logic [2:0] ser;
        rgb  = (m == 2'h0) || (m == 2'h3);
        ser2 = (m < 2'h2);
        if (s_b || (p_s && ser2)) ser = {p[12], p[13], p[14]};
        else if (rgb) ser = {p[5], p[7], p[9]};
        else if (m == 2'h1) ser = {p[6], p[8], p[10]};
        else ser = 3'h0;
        s1 = p_b ? p[15] : (rgb ? p[1] : p[2]);
        s2 = p_b ? p[16] : (((p_s || s_b) && ser2) ? p[11] : (s_b ? p[16] : (ser2 ? p[3] : p[4])));
        return {rgb & p[0], s1, s2, ser};
    endfunction

    // Sync roles {primary parallel, secondary serial, secondary parallel}
    function automatic logic [2:0] exp_roles(input logic [1:0] m, input logic p, input logic s);
        return {p & (m != 2'h0), s & (m < 2'h2), s & (m >= 2'h2)};
    endfunction

    // Compare one observed value with its expectation
    task automatic check(input string what, input logic [5:0] exp, input logic [5:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Wait a bounded number of cycles for the sync roles to settle, then compare
    task automatic wait_roles(input logic [2:0] e);
        for (int i = 0; i < 20 && roles !== e; i++) @(negedge clk);
        check("vsync roles", {3'h0, e}, {3'h0, roles});
    endtask

    // Print counts and the verdict, then stop
    task automatic tally_and_finish();
        $display("Checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        rst_n = 1'b0; link_rst_n = 1'b0; ce = 1'b1; mode = 2'h0; ps = 1'b0; sb = 1'b0;
        pb = 1'b0; pat = '1; pri_req = 1'b0; sec_req = 1'b0;
        repeat (15) @(posedge clk);
        @(negedge clk);
        check("reset pins", 6'h18, pins);
        check("reset roles", 6'h00, {3'h0, roles});
        @(posedge clk);
        rst_n <= 1'b1;
        link_rst_n <= 1'b1;
        // Every mode with every save and bypass combination, host pins changing after capture
        for (int c = 0; c < 32; c++) begin
            @(posedge clk);
            {mode, ps, sb, pb} <= c[4:0];
            for (int k = 0; k < 5; k++) begin
                @(posedge clk);
                pat <= test_pats[k];
                @(negedge clk);
                exp_p = exp_pins(mode, ps, sb, pb, test_pats[k]);
                check("valid", exp_p & 6'h20, pins & 6'h20);
                check("select one", exp_p & 6'h10, pins & 6'h10);
                check("select two", exp_p & 6'h08, pins & 6'h08);
                check("serial clock", exp_p & 6'h04, pins & 6'h04);
                check("cmd flag", exp_p & 6'h02, pins & 6'h02);
                check("serial data", exp_p & 6'h01, pins & 6'h01);
            end
        end
        // Clock enable low keeps the old selects
        @(posedge clk);
        {mode, ps, sb, pb} <= 5'h00;
        repeat (2) @(posedge clk);
        ce <= 1'b0;
        mode <= 2'h2;
        repeat (3) @(posedge clk);
        @(negedge clk);
        check("frozen selects", exp_pins(2'h0, 1'b0, 1'b0, 1'b0, pat), pins);
        @(posedge clk);
        ce <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        check("captured selects", exp_pins(2'h2, 1'b0, 1'b0, 1'b0, pat), pins);
        // Sync roles for every mode and pin combination
        for (int c = 0; c < 16; c++) begin
            @(posedge clk);
            mode <= c[3:2];
            pri_req <= c[1];
            sec_req <= c[0];
            @(negedge clk);
            wait_roles(exp_roles(c[3:2], c[1], c[0]));
        end
        // Second reset in mid-run: outputs forced, then default selects with capture held off
        @(posedge clk);
        rst_n <= 1'b0;
        ce <= 1'b0;
        mode <= 2'h1;
        sb <= 1'b1;
        pat <= test_pats[2];
        @(posedge clk);
        @(negedge clk);
        check("mid reset pins", 6'h18, pins);
        check("mid reset roles", 6'h00, {3'h0, roles});
        @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        check("default selects", exp_pins(2'h0, 1'b0, 1'b0, 1'b0, test_pats[2]), pins);
        tally_and_finish();
    end

    // Cut a hang short
    initial begin
        #50000;
        errors++;
        $display("MISMATCH watchdog expected end seen hang");
        tally_and_finish();
    end
endmodule
